// file: src/dch_decode.sv
// channel command decoder: strobes plus low address bits pick a command,
// upper five address bits are matched against the base switches
// assumes strobes and address are synchronous to the caller's clock
`timescale 1ns/1ps
`default_nettype none
`include "dch_defs.svh"

module dch_decode (
   input wire logic iowc_n,
   input wire logic iorc_n,
   input wire logic [7:0] adr,
   input wire logic [4:0] base_sw,
   output logic wr_lo,
   output logic wr_hi,
   output logic wr_rst,
   output logic rd_stat,
   output logic rd_type,
   output logic rd_byte
);
   logic hit;

   // base match on upper bits, command from strobe and low bits
   assign hit = (adr[7:3] == base_sw);
   assign wr_lo = hit & ~iowc_n & (adr[2:0] == `DCH_OFS_PTR_LO);
   assign wr_hi = hit & ~iowc_n & (adr[2:0] == `DCH_OFS_PTR_HI);
   assign wr_rst = hit & ~iowc_n & (adr[2:0] == `DCH_OFS_RESET);
   assign rd_stat = hit & ~iorc_n & (adr[2:0] == `DCH_OFS_STATUS);
   assign rd_type = hit & ~iorc_n & (adr[2:0] == `DCH_OFS_TYPE);
   assign rd_byte = hit & ~iorc_n & (adr[2:0] == `DCH_OFS_RESULT);
endmodule

`default_nettype wire

// file: src/dch_defs.svh
// constants for the diskette channel host port: port offsets, parameter
// block layout, channel word fields, status bits, host register map, timing
// assumes it is included by bare name wherever a constant is needed
`ifndef DCH_DEFS_SVH
`define DCH_DEFS_SVH

// channel command offsets within the eight-port window
`define DCH_OFS_STATUS 3'h0
`define DCH_OFS_TYPE 3'h1
`define DCH_OFS_PTR_LO 3'h1
`define DCH_OFS_PTR_HI 3'h2
`define DCH_OFS_RESULT 3'h3
`define DCH_OFS_RESET 3'h7

// parameter block byte indices
`define DCH_PB_CW 3'h0
`define DCH_PB_OP 3'h1
`define DCH_PB_CNT 3'h2
`define DCH_PB_TRK 3'h3
`define DCH_PB_SEC 3'h4
`define DCH_PB_BUFL 3'h5
`define DCH_PB_BUFH 3'h6
`define DCH_PB_LAST 3'h6

// channel word fields
`define DCH_CW_WLEN 2
`define DCH_CW_IE_DONE 3
`define DCH_CW_IE_RDY 4
`define DCH_CW_RANDOM 6
`define DCH_CW_RESET 8'h18

// result type codes
`define DCH_RT_DONE 2'h0
`define DCH_RT_RDY 2'h2

// subsystem status bit positions
`define DCH_ST_RDY0 0
`define DCH_ST_RDY1 1
`define DCH_ST_INT 2
`define DCH_ST_PRES 3
`define DCH_ST_DD 4
`define DCH_ST_RDY2 5
`define DCH_ST_RDY3 6

// host apb register map
`define DCH_APB_CMD 12'h000
`define DCH_APB_STAT 12'h004
`define DCH_APB_MEM 12'h040
`define DCH_APB_MEM_MASK 12'hfc0
`define DCH_MEM_AW 4

// timing at 40 mhz
`define DCH_CLK_MHZ 40
`define DCH_T_OUT_NS 3000
`define DCH_T_IN_NS 1000
`define DCH_ACK_OUT_CYC ((`DCH_T_OUT_NS * `DCH_CLK_MHZ) / 1000)
`define DCH_ACK_IN_CYC ((`DCH_T_IN_NS * `DCH_CLK_MHZ) / 1000)
`define DCH_TMO_NS 10000
`define DCH_TMO_CYC ((`DCH_TMO_NS * `DCH_CLK_MHZ) / 1000)

`endif

// file: src/dch_device.sv
// diskette channel device end: channel command ports, parameter block
// fetch as bus master, result and interrupt reporting, ready tracking
// assumes the user side runs each operation and pulses op_done when over
`timescale 1ns/1ps
`default_nettype none
`include "dch_defs.svh"

////////////////////////////////////////////////////////////////////////////
module dch_device (
   input wire logic pclk,
   input wire logic presetn,
   input wire logic ce,
   input wire logic [4:0] base_sw,
   dch_if.dev bus,
   input wire logic [3:0] drive_ready,
   output logic op_start,
   output dch_pkg::dch_byte_t op_code,
   output dch_pkg::dch_byte_t op_count,
   output dch_pkg::dch_byte_t op_track,
   output dch_pkg::dch_byte_t op_sector,
   output logic [15:0] op_buf,
   output logic cw_random,
   output logic cw_wlen,
   input wire logic op_done,
   input wire logic [7:0] op_err,
   output logic busy
);
   import dch_pkg::*;

   logic wr_lo, wr_hi, wr_rst, rd_stat, rd_type, rd_byte;
   logic strobe, allowed, accept, srst, rdy_event;
   logic served_reg, ack_reg, int_reg, op_start_reg;
   logic [7:0] dat_r_reg, ptr_lo_reg, ptr_hi_reg, cw_reg;
   logic [7:0] res_type_reg, res_byte_reg, status_w;
   logic [3:0] last_rep_reg, fall_reg, rdy_prev_reg, rep_w;
   logic [2:0] idx_reg;
   logic [7:0] pblk [0:6];
   dch_dev_state_e state_reg;

   ////////////////////////////////////////////////////////////////////////
   // command decode

   dch_decode u_dec (
      .iowc_n(bus.iowc_n),
      .iorc_n(bus.iorc_n),
      .adr(bus.adr[7:0]),
      .base_sw(base_sw),
      .wr_lo(wr_lo),
      .wr_hi(wr_hi),
      .wr_rst(wr_rst),
      .rd_stat(rd_stat),
      .rd_type(rd_type),
      .rd_byte(rd_byte)
   );

   // which commands are honoured now
   assign busy = (state_reg != DEV_IDLE);
   assign strobe = ~bus.iowc_n | ~bus.iorc_n;
   assign allowed = wr_rst | rd_stat | rd_type
      | (~busy & (wr_lo | wr_hi | rd_byte));
   assign accept = strobe & ~served_reg & allowed;
   assign srst = accept & wr_rst;

   // status byte from live ready lines and interrupt flip-flop
   always_comb begin
      status_w = 8'h00;
      status_w[`DCH_ST_RDY0] = drive_ready[0];
      status_w[`DCH_ST_RDY1] = drive_ready[1];
      status_w[`DCH_ST_INT] = int_reg;
      status_w[`DCH_ST_PRES] = 1'b1;
      status_w[`DCH_ST_DD] = 1'b1;
      status_w[`DCH_ST_RDY2] = drive_ready[2];
      status_w[`DCH_ST_RDY3] = drive_ready[3];
   end

   ////////////////////////////////////////////////////////////////////////
   // acknowledge path: data lands one edge, acknowledge the next

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         served_reg <= 1'b0;
         ack_reg <= 1'b0;
         dat_r_reg <= 8'h00;
      end else if (ce) begin
         if (!strobe) begin
            served_reg <= 1'b0;
         end else if (accept) begin
            served_reg <= 1'b1;
         end
         ack_reg <= served_reg & strobe;
         if (accept & rd_stat) begin
            dat_r_reg <= status_w;
         end else if (accept & rd_type) begin
            dat_r_reg <= res_type_reg;
         end else if (accept & rd_byte) begin
            dat_r_reg <= res_byte_reg;
         end
      end
   end

   assign bus.xack_n = ~ack_reg;
   assign bus.dat_r = dat_r_reg;

   ////////////////////////////////////////////////////////////////////////
   // block pointer

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         ptr_lo_reg <= 8'h00;
         ptr_hi_reg <= 8'h00;
      end else if (ce) begin
         if (srst) begin
            ptr_lo_reg <= 8'h00;
            ptr_hi_reg <= 8'h00;
         end else begin
            if (accept & wr_lo) begin
               ptr_lo_reg <= bus.dat_w;
            end
            if (accept & wr_hi) begin
               ptr_hi_reg <= bus.dat_w;
            end
         end
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // sequencer: start, bus request, seven-byte fetch, run

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         state_reg <= DEV_IDLE;
         idx_reg <= 3'h0;
         op_start_reg <= 1'b0;
      end else if (ce) begin
         op_start_reg <= 1'b0;
         if (srst) begin
            state_reg <= DEV_IDLE;
            idx_reg <= 3'h0;
         end else begin
            case (state_reg)
               DEV_IDLE: begin
                  if (accept & wr_hi) begin
                     state_reg <= DEV_REQ;
                     idx_reg <= 3'h0;
                  end
               end
               DEV_REQ: begin
                  if (!bus.bgnt_n) begin
                     state_reg <= DEV_READ;
                  end
               end
               DEV_READ: begin
                  if (!bus.mack_n) begin
                     state_reg <= DEV_GAP;
                  end
               end
               DEV_GAP: begin
                  if (bus.mack_n) begin
                     if (idx_reg == `DCH_PB_LAST) begin
                        state_reg <= DEV_RUN;
                        op_start_reg <= 1'b1;
                     end else begin
                        idx_reg <= idx_reg + 3'h1;
                        state_reg <= DEV_READ;
                     end
                  end
               end
               DEV_RUN: begin
                  if (op_done) begin
                     state_reg <= DEV_IDLE;
                  end
               end
               default: begin
                  state_reg <= DEV_IDLE;
               end
            endcase
         end
      end
   end

   // fetched parameter bytes
   always_ff @(posedge pclk) begin
      if (ce && state_reg == DEV_READ && !bus.mack_n) begin
         pblk[idx_reg] <= bus.mdat;
      end
   end

   // channel word, kept for interrupt enables and user fields
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         cw_reg <= `DCH_CW_RESET;
      end else if (ce) begin
         if (srst) begin
            cw_reg <= `DCH_CW_RESET;
         end else if (op_start_reg) begin
            cw_reg <= pblk[`DCH_PB_CW];
         end
      end
   end

   assign bus.breq_n = ~(state_reg == DEV_REQ || state_reg == DEV_READ || state_reg == DEV_GAP);
   assign bus.mrdc_n = ~(state_reg == DEV_READ);
   assign bus.madr = {ptr_hi_reg, ptr_lo_reg} + {13'h0000, idx_reg};
   assign op_start = op_start_reg;
   assign op_code = pblk[`DCH_PB_OP];
   assign op_count = pblk[`DCH_PB_CNT];
   assign op_track = pblk[`DCH_PB_TRK];
   assign op_sector = pblk[`DCH_PB_SEC];
   assign op_buf = {pblk[`DCH_PB_BUFH], pblk[`DCH_PB_BUFL]};
   assign cw_random = cw_reg[`DCH_CW_RANDOM];
   assign cw_wlen = cw_reg[`DCH_CW_WLEN];

   ////////////////////////////////////////////////////////////////////////
   // ready tracking: drops seen while busy are reported first

   assign rep_w = drive_ready & ~fall_reg;
   assign rdy_event = (drive_ready != last_rep_reg) | (fall_reg != 4'h0);

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         rdy_prev_reg <= 4'h0;
      end else if (ce) begin
         rdy_prev_reg <= drive_ready;
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // results and interrupt flip-flop; a new event beats the read clear

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         int_reg <= 1'b0;
         res_type_reg <= 8'h00;
         res_byte_reg <= 8'h00;
         last_rep_reg <= 4'h0;
         fall_reg <= 4'h0;
      end else if (ce) begin
         if (srst) begin
            int_reg <= 1'b0;
            res_type_reg <= 8'h00;
            res_byte_reg <= 8'h00;
            last_rep_reg <= 4'h0;
            fall_reg <= 4'h0;
         end else begin
            if (accept & rd_byte) begin
               int_reg <= 1'b0;
            end
            if (busy) begin
               fall_reg <= fall_reg | (rdy_prev_reg & ~drive_ready);
            end
            if (state_reg == DEV_RUN && op_done) begin
               res_type_reg <= {6'h00, `DCH_RT_DONE};
               res_byte_reg <= op_err;
               if (cw_reg[`DCH_CW_IE_DONE]) begin
                  int_reg <= 1'b1;
               end
            end else if (!busy && !int_reg && rdy_event) begin
               res_type_reg <= {6'h00, `DCH_RT_RDY};
               res_byte_reg <= {4'h0, rep_w};
               last_rep_reg <= rep_w;
               fall_reg <= 4'h0;
               if (cw_reg[`DCH_CW_IE_RDY]) begin
                  int_reg <= 1'b1;
               end
            end
         end
      end
   end

   assign bus.int_n = ~int_reg;
endmodule

`default_nettype wire

// file: src/dch_host.sv
// host cpu end: apb registers order one channel command at a time, serve
// the device's memory fetches from a small shared memory, time out stalls
// assumes apb software waits for busy to clear before the next command
`timescale 1ns/1ps
`default_nettype none
`include "dch_defs.svh"

module dch_host (
   input wire logic pclk,
   input wire logic presetn,
   input wire logic ce,
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [11:0] paddr,
   input wire logic [31:0] pwdata,
   output logic [31:0] prdata,
   output logic pready,
   output logic pslverr,
   input wire logic [4:0] base_sw,
   dch_if.host bus
);
   import dch_pkg::*;

   dch_hst_state_e state_reg;
   logic [2:0] port_reg;
   logic rd_reg, tmo_reg, gnt_reg, mack_reg, is_cmd, is_stat, is_mem, wr_acc;
   logic [7:0] wdat_reg, rdat_reg, mdat_reg;
   logic [9:0] cnt_reg;
   logic [7:0] mem [0:15];

   ////////////////////////////////////////////////////////////////////////
   // apb slave, zero wait states

   assign is_cmd = (paddr == `DCH_APB_CMD);
   assign is_stat = (paddr == `DCH_APB_STAT);
   assign is_mem = ((paddr & `DCH_APB_MEM_MASK) == `DCH_APB_MEM);
   assign wr_acc = psel & penable & pwrite;
   assign pready = 1'b1;
   assign pslverr = psel & penable & ~(is_cmd | is_stat | is_mem);

   always_comb begin
      prdata = 32'h00000000;
      if (is_cmd) begin
         prdata = {16'h0000, wdat_reg, 4'h0, rd_reg, port_reg};
      end else if (is_stat) begin
         prdata = {16'h0000, rdat_reg, 5'h00, ~bus.int_n, tmo_reg, state_reg != HST_IDLE};
      end else if (is_mem) begin
         prdata = {24'h000000, mem[paddr[5:2]]};
      end
   end

   // shared memory holding parameter blocks, written by software
   always_ff @(posedge pclk) begin
      if (ce && wr_acc && is_mem) begin
         mem[paddr[5:2]] <= pwdata[7:0];
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // i/o cycle engine with timeout

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         state_reg <= HST_IDLE;
         port_reg <= 3'h0;
         rd_reg <= 1'b0;
         wdat_reg <= 8'h00;
         rdat_reg <= 8'h00;
         tmo_reg <= 1'b0;
         cnt_reg <= 10'h000;
      end else if (ce) begin
         case (state_reg)
            HST_IDLE: begin
               if (wr_acc && is_cmd) begin
                  port_reg <= pwdata[2:0];
                  rd_reg <= pwdata[3];
                  wdat_reg <= pwdata[15:8];
                  tmo_reg <= 1'b0;
                  cnt_reg <= 10'h000;
                  state_reg <= HST_STROBE;
               end
            end
            HST_STROBE: begin
               cnt_reg <= cnt_reg + 10'h001;
               if (!bus.xack_n) begin
                  if (rd_reg) begin
                     rdat_reg <= bus.dat_r;
                  end
                  state_reg <= HST_REL;
               end else if (cnt_reg == 10'(`DCH_TMO_CYC)) begin
                  tmo_reg <= 1'b1;
                  state_reg <= HST_REL;
               end
            end
            HST_REL: begin
               if (bus.xack_n) begin
                  state_reg <= HST_IDLE;
               end
            end
            default: begin
               state_reg <= HST_IDLE;
            end
         endcase
      end
   end

   // address duplicated on both halves, data held through the strobe
   assign bus.iowc_n = ~(state_reg == HST_STROBE && !rd_reg);
   assign bus.iorc_n = ~(state_reg == HST_STROBE && rd_reg);
   assign bus.adr = {base_sw, port_reg, base_sw, port_reg};
   assign bus.dat_w = wdat_reg;

   ////////////////////////////////////////////////////////////////////////
   // memory slave for the device's block fetch

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         gnt_reg <= 1'b0;
         mack_reg <= 1'b0;
         mdat_reg <= 8'h00;
      end else if (ce) begin
         gnt_reg <= ~bus.breq_n;
         mack_reg <= ~bus.mrdc_n & gnt_reg;
         if (!bus.mrdc_n) begin
            mdat_reg <= mem[bus.madr[`DCH_MEM_AW-1:0]];
         end
      end
   end

   assign bus.bgnt_n = ~gnt_reg;
   assign bus.mack_n = ~mack_reg;
   assign bus.mdat = mdat_reg;
endmodule

`default_nettype wire

// file: src/dch_if.sv
// system bus between host cpu side and diskette channel: i/o strobes,
// port address, data both ways, acknowledge, interrupt, memory fetch path
// assumes the bench joins a host end and a device end through it
`timescale 1ns/1ps
`default_nettype none

interface dch_if;
   logic iowc_n;
   logic iorc_n;
   logic [15:0] adr;
   logic [7:0] dat_w;
   logic [7:0] dat_r;
   logic xack_n;
   logic int_n;
   logic breq_n;
   logic bgnt_n;
   logic mrdc_n;
   logic [15:0] madr;
   logic [7:0] mdat;
   logic mack_n;

   modport dev (
      input iowc_n, iorc_n, adr, dat_w, bgnt_n, mdat, mack_n,
      output dat_r, xack_n, int_n, breq_n, mrdc_n, madr
   );
   modport host (
      output iowc_n, iorc_n, adr, dat_w, bgnt_n, mdat, mack_n,
      input dat_r, xack_n, int_n, breq_n, mrdc_n, madr
   );
endinterface

`default_nettype wire

// file: src/dch_pkg.sv
// types shared by both ends of the diskette channel host port
// assumes nothing beyond a systemverilog compiler
package dch_pkg;

   // device end sequencing
   typedef enum logic [4:0] {
      DEV_IDLE = 5'h01,
      DEV_REQ  = 5'h02,
      DEV_READ = 5'h04,
      DEV_GAP  = 5'h08,
      DEV_RUN  = 5'h10
   } dch_dev_state_e;

   // host end i/o cycle sequencing
   typedef enum logic [2:0] {
      HST_IDLE   = 3'h1,
      HST_STROBE = 3'h2,
      HST_REL    = 3'h4
   } dch_hst_state_e;

   typedef logic [7:0] dch_byte_t;

endpackage

// file: tb/dch_props.sv
// checker for the system bus between host end and device end
// assumes the bench wires it to the shared interface and device busy
`timescale 1ns/1ps
`default_nettype none

module dch_props (
   input wire logic pclk,
   input wire logic presetn,
   input wire logic iowc_n,
   input wire logic iorc_n,
   input wire logic [15:0] adr,
   input wire logic [7:0] dat_r,
   input wire logic xack_n,
   input wire logic breq_n,
   input wire logic mrdc_n,
   input wire logic [15:0] madr,
   input wire logic busy
);
   default clocking cb @(posedge pclk); endclocking
   default disable iff (!presetn);
   logic mr_q;
   logic seen;
   logic [3:0] cnt;
   logic [15:0] nxt_madr;

   ////////////////////////////////////////
   // track block fetch order and length within one bus tenure
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         mr_q <= 1'b1;
         seen <= 1'b0;
         cnt <= 4'h0;
         nxt_madr <= 16'h0000;
      end else begin
         mr_q <= mrdc_n;
         if (breq_n) begin
            seen <= 1'b0;
            cnt <= 4'h0;
         end else if (mr_q && !mrdc_n) begin
            seen <= 1'b1;
            cnt <= cnt + 4'h1;
            nxt_madr <= madr + 16'h0001;
         end
      end
   end

   ////////////////////////////////////////
   property p_out_ack;
      !busy && $fell(iowc_n) && (adr[2:0] inside {3'h1, 3'h2, 3'h7}) |-> ##[1:120] !xack_n;
   endproperty
   a_out_ack: assert property (p_out_ack) else $error("idle output command not acknowledged");
   property p_rst_ack;
      busy && $fell(iowc_n) && adr[2:0] == 3'h7 |-> ##[1:120] !xack_n;
   endproperty
   a_rst_ack: assert property (p_rst_ack) else $error("reset while busy not acknowledged");
   property p_ptr_busy;
      busy && $fell(iowc_n) && (adr[2:0] inside {3'h1, 3'h2}) |-> xack_n [*8];
   endproperty
   a_ptr_busy: assert property (p_ptr_busy) else $error("pointer write acknowledged while busy");
   property p_rd_ack;
      $fell(iorc_n) && (adr[2:0] inside {3'h0, 3'h1}) |-> ##[1:40] !xack_n;
   endproperty
   a_rd_ack: assert property (p_rd_ack) else $error("status or type read slow");
   property p_res_busy;
      busy && $fell(iorc_n) && adr[2:0] == 3'h3 |-> xack_n [*8];
   endproperty
   a_res_busy: assert property (p_res_busy) else $error("result read acknowledged while busy");
   property p_dat_first;
      !iorc_n && $fell(xack_n) |-> $stable(dat_r);
   endproperty
   a_dat_first: assert property (p_dat_first) else $error("read data changed with acknowledge");
   property p_ack_cause;
      $fell(xack_n) |-> !$past(iowc_n) || !$past(iorc_n);
   endproperty
   a_ack_cause: assert property (p_ack_cause) else $error("acknowledge without strobe");
   property p_stat_fix;
      !iorc_n && $fell(xack_n) && adr[2:0] == 3'h0 |-> dat_r[4:3] == 2'b11 && !dat_r[7];
   endproperty
   a_stat_fix: assert property (p_stat_fix) else $error("status presence bits wrong");
   property p_fetch_seq;
      mr_q && !mrdc_n && seen |-> madr == nxt_madr;
   endproperty
   a_fetch_seq: assert property (p_fetch_seq) else $error("block fetch address out of order");
   property p_fetch_len;
      $rose(breq_n) |-> cnt == 4'h7;
   endproperty
   a_fetch_len: assert property (p_fetch_len) else $error("block fetch length wrong");
endmodule

`default_nettype wire

// file: tb/test_disk_channel_host_port.sv
// bench joining host end and device end, driven over apb
// assumes both ends, the interface and the checker are compiled first
`timescale 1ns/1ps
`default_nettype none
`include "dch_defs.svh"

module test_disk_channel_host_port;
   import dch_pkg::*;
   logic pclk = 0, presetn = 0, psel = 0, penable = 0, pwrite = 0, op_done = 0;
   logic [11:0] paddr = 12'h000;
   logic [31:0] pwdata = 32'h0, prdata, r;
   logic pready, pslverr, op_start, cw_random, cw_wlen, busy, tmo, err;
   logic [3:0] drive_ready = 4'h0;
   logic [7:0] op_err = 8'h00, q;
   dch_byte_t op_code, op_count, op_track, op_sector;
   logic [15:0] op_buf;
   logic [7:0] pb [0:6] = '{8'h5c, 8'h03, 8'h02, 8'h21, 8'h05, 8'h34, 8'h12};
   int fail_count = 0, n_tests = 0, n_start = 0, i;

   dch_if i_dch_if();
   dch_device i_dch_device(.pclk, .presetn, .ce(1'b1), .base_sw(5'h0f), .bus(i_dch_if.dev), .drive_ready,
      .op_start, .op_code, .op_count, .op_track, .op_sector, .op_buf, .cw_random, .cw_wlen, .op_done,
      .op_err, .busy);
   dch_host i_dch_host(.pclk, .presetn, .ce(1'b1), .psel, .penable, .pwrite, .paddr, .pwdata, .prdata,
      .pready, .pslverr, .base_sw(5'h0f), .bus(i_dch_if.host));
   dch_props i_dch_props(.pclk, .presetn, .iowc_n(i_dch_if.iowc_n), .iorc_n(i_dch_if.iorc_n),
      .adr(i_dch_if.adr), .dat_r(i_dch_if.dat_r), .xack_n(i_dch_if.xack_n), .breq_n(i_dch_if.breq_n),
      .mrdc_n(i_dch_if.mrdc_n), .madr(i_dch_if.madr), .busy);

   ////////////////////////////////////////
   // clock and operation start counter
   initial begin
      forever #12.5 pclk = ~pclk;
   end
   always @(posedge pclk) begin
      if (op_start === 1'b1) n_start <= n_start + 1;
   end

   ////////////////////////////////////////
   task automatic wrap_up();
      $display("comparisons %0d mismatches %0d", n_tests, fail_count);
      if (fail_count == 0 && n_tests > 0) begin
         $display("All checks passed");
      end else begin
         $display("Checks failed");
      end
      $finish;
   endtask
   task automatic tmo_out();
      fail_count++;
      wrap_up();
   endtask
   task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
      n_tests++;
      if (seen !== exp) begin
         fail_count++;
         $display("mismatch %s expected %h seen %h", nm, exp, seen);
      end
   endtask
   // one apb transfer, idle cycle first
   task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] d);
      int k;
      @(posedge pclk);
      psel <= 1'b1;
      pwrite <= wr;
      paddr <= a;
      pwdata <= d;
      @(posedge pclk);
      penable <= 1'b1;
      for (k = 0; k < 50; k++) begin
         @(posedge pclk);
         if (pready === 1'b1) break;
      end
      r = prdata;
      err = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
      if (k == 50) tmo_out();
   endtask
   // one channel command, then poll until the host end is free
   task automatic io(input logic [2:0] port, input logic rd, input logic [7:0] d);
      int k;
      apb(1'b1, `DCH_APB_CMD, {16'h0000, d, 4'h0, rd, port});
      for (k = 0; k < 1000; k++) begin
         apb(1'b0, `DCH_APB_STAT, 32'h0);
         if (r[0] === 1'b0) break;
      end
      if (k == 1000) tmo_out();
      q = r[15:8];
      tmo = r[1];
   endtask
   task automatic wait_int();
      int k;
      for (k = 0; k < 200; k++) begin
         apb(1'b0, `DCH_APB_STAT, 32'h0);
         if (r[2] === 1'b1) break;
      end
      if (k == 200) tmo_out();
   endtask
   task automatic wait_start(input int n);
      int k;
      for (k = 0; k < 300; k++) begin
         @(posedge pclk);
         if (n_start >= n) break;
      end
      if (k == 300) tmo_out();
   endtask

   ////////////////////////////////////////
   // main sequence
   initial begin
      repeat (16) @(posedge pclk);
      presetn <= 1'b1;
      for (i = 0; i < 7; i++) apb(1'b1, `DCH_APB_MEM + 12'(4 * (i + 4)), {24'h0, pb[i]});
      apb(1'b0, 12'h020, 32'h0);
      chk("unmapped error", err, 1);
      io(`DCH_OFS_STATUS, 1'b1, 8'h00);
      chk("idle status", q, 8'h18);
      chk("status ack", tmo, 0);
      io(`DCH_OFS_PTR_LO, 1'b0, 8'h04);
      chk("low ack", tmo, 0);
      io(`DCH_OFS_PTR_HI, 1'b0, 8'h00);
      chk("high ack", tmo, 0);
      wait_start(1);
      chk("op code", op_code, pb[1]);
      chk("count", op_count, pb[2]);
      chk("track", op_track, pb[3]);
      chk("sector", op_sector, pb[4]);
      chk("buffer", op_buf, {pb[6], pb[5]});
      chk("numbering", cw_random, 1);
      chk("word length", cw_wlen, 1);
      chk("busy", busy, 1);
      io(`DCH_OFS_PTR_LO, 1'b0, 8'h55);
      chk("busy pointer", tmo, 1);
      io(`DCH_OFS_RESULT, 1'b1, 8'h00);
      chk("busy result", tmo, 1);
      io(`DCH_OFS_STATUS, 1'b1, 8'h00);
      chk("busy status", q, 8'h18);
      // finish the operation with error flags
      @(posedge pclk);
      op_err <= 8'h5a;
      op_done <= 1'b1;
      @(posedge pclk);
      op_done <= 1'b0;
      repeat (2) @(posedge pclk);
      chk("done busy", busy, 0);
      wait_int();
      io(`DCH_OFS_TYPE, 1'b1, 8'h00);
      chk("done type", q, 8'h00);
      io(`DCH_OFS_RESULT, 1'b1, 8'h00);
      chk("done byte", q, 8'h5a);
      io(`DCH_OFS_STATUS, 1'b1, 8'h00);
      chk("cleared status", q, 8'h18);
      // drives 0 and 2 come ready
      drive_ready <= 4'h5;
      wait_int();
      io(`DCH_OFS_STATUS, 1'b1, 8'h00);
      chk("ready status", q, 8'h3d);
      io(`DCH_OFS_TYPE, 1'b1, 8'h00);
      chk("ready type", q, 8'h02);
      io(`DCH_OFS_RESULT, 1'b1, 8'h00);
      chk("ready byte", q, 8'h05);
      // reset command in mid operation
      io(`DCH_OFS_PTR_LO, 1'b0, 8'h04);
      io(`DCH_OFS_PTR_HI, 1'b0, 8'h00);
      wait_start(2);
      io(`DCH_OFS_RESET, 1'b0, 8'hff);
      chk("reset ack", tmo, 0);
      chk("reset busy", busy, 0);
      wait_int();
      io(`DCH_OFS_TYPE, 1'b1, 8'h00);
      chk("reset type", q, 8'h02);
      io(`DCH_OFS_RESULT, 1'b1, 8'h00);
      chk("reset byte", q, 8'h05);
      // drive 2 drops and recovers during an operation
      io(`DCH_OFS_PTR_LO, 1'b0, 8'h04);
      io(`DCH_OFS_PTR_HI, 1'b0, 8'h00);
      wait_start(3);
      drive_ready <= 4'h1;
      repeat (4) @(posedge pclk);
      drive_ready <= 4'h5;
      @(posedge pclk);
      op_err <= 8'h00;
      op_done <= 1'b1;
      @(posedge pclk);
      op_done <= 1'b0;
      wait_int();
      io(`DCH_OFS_TYPE, 1'b1, 8'h00);
      chk("flap done type", q, 8'h00);
      io(`DCH_OFS_RESULT, 1'b1, 8'h00);
      chk("flap done byte", q, 8'h00);
      wait_int();
      io(`DCH_OFS_TYPE, 1'b1, 8'h00);
      chk("drop type", q, 8'h02);
      io(`DCH_OFS_RESULT, 1'b1, 8'h00);
      chk("drop byte", q, 8'h01);
      wait_int();
      io(`DCH_OFS_TYPE, 1'b1, 8'h00);
      chk("recover type", q, 8'h02);
      io(`DCH_OFS_RESULT, 1'b1, 8'h00);
      chk("recover byte", q, 8'h05);
      wrap_up();
   end
endmodule

`default_nettype wire
